// ---- jpwv_cfg_reg.sv ----
// default configuration word written one byte per set verb
`timescale 1ns/100ps
module jpwv_cfg_reg #(
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
    input logic clk,
    input logic srst,
    input logic ce,
    input logic wr,
    input logic [1:0] byte_sel,
    input logic [7:0] data,
    output logic [31:0] cfg
);
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            logic [7:0] byte_q;
            always_ff @(posedge clk) begin
                if (srst) begin
                    byte_q <= RESET_VALUE[g*8 +: 8];
                end else if (ce && wr && (byte_sel == 2'(g))) begin
                    byte_q <= data;
                end
            end
            assign cfg[g*8 +: 8] = byte_q;
        end
    endgenerate
endmodule

// ---- jpwv_defs.svh ----
// constants for the jack pin widget verb block
`ifndef JPWV_DEFS_SVH
`define JPWV_DEFS_SVH

`define JPWV_NODE_D 7'h0D
`define JPWV_NODE_E 7'h0E
`define JPWV_NODE_F 7'h0F

`define JPWV_VERB_W 12
`define JPWV_VERB_GET_PARAM 12'hF00
`define JPWV_VERB_GET_LIST 12'hF02
`define JPWV_VERB_GET_PIN_CONTROL 12'hF07
`define JPWV_VERB_SET_PIN_CONTROL 12'h707
`define JPWV_VERB_GET_UNSOL 12'hF08
`define JPWV_VERB_SET_UNSOL 12'h708
`define JPWV_VERB_GET_SENSE 12'hF09
`define JPWV_VERB_SET_SENSE 12'h709
`define JPWV_VERB_GET_CFG 12'hF1C
`define JPWV_VERB_SET_CFG_HI 10'h1C7
`define JPWV_CFG_SEL_LSB 2

`define JPWV_PARAM_WIDGET_CAPS 8'h09
`define JPWV_PARAM_PIN_CAPS 8'h0C
`define JPWV_PARAM_LISTLEN 8'h0E

`define JPWV_RSP_ZERO 32'h0000_0000
`define JPWV_WIDGET_CAPS_F_BASE 32'h0040_0081
`define JPWV_WIDGET_CAPS_LIST_MASK 32'h0000_0100
`define JPWV_BIAS_CAPS 8'h17
`define JPWV_PIN_CAPS_LOW 8'h37
`define JPWV_PIN_CAPS_HIGH 16'h0000
`define JPWV_LIST_LEN_E 32'h0000_0001
`define JPWV_LIST_ENTRIES_E 32'h0000_0010

`define JPWV_CFG_RESET_D 32'h0121_401F
`define JPWV_CFG_RESET_E 32'h0101_1010
`define JPWV_CFG_OVERRIDE_BIT 8
`define JPWV_CFG_MISC_HI 11
`define JPWV_CFG_MISC_LO 8

`define JPWV_BIAS_HIZ 3'h0
`define JPWV_PIN_CONTROL_RESET 8'h00
`define JPWV_UNSOL_RESET 8'h00
`define JPWV_IMP_ALL_ONES 31'h7FFF_FFFF
`define JPWV_UNSOL_PAD 26'h000_0000

`endif

// ---- jpwv_meas_model.sv ----
// impedance measurer model answering start pulses after a set delay
`timescale 1ns/100ps
module jpwv_meas_model #(
    parameter logic [30:0] VAL_R = 31'h0000_1234,
    parameter logic [30:0] VAL_L = 31'h0000_0567
) (
    input logic clk,
    input logic srst,
    input logic [7:0] dly,
    input logic start,
    input logic right,
    output logic done,
    output logic [30:0] value
);
    logic busy_q, side_q;
    logic [7:0] cnt_q;
    logic [30:0] noise_q;
    // value means nothing outside done, so it keeps moving
    assign value = done ? (side_q ? VAL_R : VAL_L) : noise_q;
    always_ff @(posedge clk) begin
        noise_q <= {noise_q[29:0], ~noise_q[30]};
        done <= 1'b0;
        if (srst) begin
            busy_q <= 1'b0;
            noise_q <= 31'h2AAA_AAAA;
        end else if (start) begin
            busy_q <= 1'b1;
            side_q <= right;
            cnt_q <= dly;
        end else if (busy_q) begin
            if (cnt_q == 8'h00) begin
                done <= 1'b1;
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// ---- jpwv_pkg.sv ----
// types shared by the jack pin widget verb block
package jpwv_pkg;

    typedef struct packed {
        logic [6:0] node;
        logic [11:0] verb;
        logic [7:0] payload;
    } jpwv_cmd_s;

    typedef struct packed {
        logic rsvd_hi;
        logic out_en;
        logic in_en;
        logic [1:0] rsvd_lo;
        logic [2:0] bias;
    } jpwv_pin_control_s;

    typedef struct packed {
        logic en;
        logic rsvd;
        logic [5:0] tag;
    } jpwv_unsol_s;

    typedef enum logic [1:0] {
        JPWV_SENSE_IDLE = 2'b01,
        JPWV_SENSE_BUSY = 2'b10
    } jpwv_sense_e;

    typedef logic [31:0] jpwv_word_t;

endpackage

// ---- jpwv_sync.sv ----
// three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/100ps
module jpwv_sync (
    input logic clk,
    input logic srst,
    input logic ce,
    input logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // change taken only once the last two stages agree
    always_ff @(posedge clk) begin
        if (srst) begin
            level_q <= 1'b0;
        end else if (ce && (s2_q == s3_q)) begin
            level_q <= s3_q;
        end
    end

    assign level = level_q;
endmodule

// ---- jpwv_top.sv ----
// verb decoder and state for the jack pin widget nodes
`timescale 1ns/100ps
`include "jpwv_defs.svh"
module jpwv_top (
    input logic CLK_SYS,
    input logic SRST,
    input logic CE,
    input logic CMD_VALID,
    input jpwv_pkg::jpwv_cmd_s CMD,
    output logic RSP_VALID,
    output jpwv_pkg::jpwv_word_t RSP_DATA,
    output logic UNSOL_VALID,
    input logic UNSOL_READY,
    output jpwv_pkg::jpwv_word_t UNSOL_DATA,
    input logic JACK_E_PRESENT_PIN,
    input logic SECOND_CONV_EN,
    output logic IMP_START,
    output logic IMP_RIGHT,
    input logic IMP_DONE,
    input logic [30:0] IMP_VALUE,
    output logic JACK_E_OUT_EN,
    output logic JACK_E_IN_EN,
    output logic [2:0] JACK_E_BIAS,
    output logic JACK_D_DETECT_OVERRIDE
);
    import jpwv_pkg::*;

    localparam jpwv_word_t PIN_CAPS_E =
        {`JPWV_PIN_CAPS_HIGH, `JPWV_BIAS_CAPS, `JPWV_PIN_CAPS_LOW};
    localparam jpwv_word_t WIDGET_CAPS_E =
        `JPWV_WIDGET_CAPS_F_BASE | `JPWV_WIDGET_CAPS_LIST_MASK;
    localparam logic [7:0] BIAS_CAPS = `JPWV_BIAS_CAPS;

    function automatic logic is_cmd(input jpwv_cmd_s c,
                                    input logic [6:0] n,
                                    input logic [11:0] v);
        is_cmd = (c.node == n) && (c.verb == v);
    endfunction

    function automatic logic is_cfg_set(input jpwv_cmd_s c,
                                        input logic [6:0] n);
        is_cfg_set = (c.node == n) &&
            (c.verb[`JPWV_VERB_W-1:`JPWV_CFG_SEL_LSB] ==
             `JPWV_VERB_SET_CFG_HI);
    endfunction

    function automatic logic [2:0] bias_fix(input logic [2:0] v);
        bias_fix = BIAS_CAPS[v] ? v : `JPWV_BIAS_HIZ;
    endfunction

    logic take;
    jpwv_word_t rsp_d;
    jpwv_word_t rsp_q;
    logic rsp_valid_q;
    jpwv_word_t cfg_d;
    jpwv_word_t cfg_e;
    jpwv_word_t widget_caps_f;
    jpwv_pin_control_s pin_control_q;
    jpwv_pin_control_s pin_wr;
    jpwv_unsol_s unsol_q;
    jpwv_sense_e sense_q;
    logic [30:0] imp_q;
    logic side_q;
    logic start_q;
    logic sense_done;
    logic present_s;
    logic present_eff;
    logic present_prev_q;
    logic insert;
    logic unsol_event;
    logic pending_q;
    logic pending_d;
    jpwv_word_t unsol_data_q;

    assign take = CE && CMD_VALID;
    assign pin_wr = jpwv_pin_control_s'(CMD.payload);

    jpwv_cfg_reg #(
        .RESET_VALUE(`JPWV_CFG_RESET_D)
    ) u_cfg_d (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .wr(CMD_VALID && is_cfg_set(CMD, `JPWV_NODE_D)),
        .byte_sel(CMD.verb[`JPWV_CFG_SEL_LSB-1:0]),
        .data(CMD.payload),
        .cfg(cfg_d)
    );

    jpwv_cfg_reg #(
        .RESET_VALUE(`JPWV_CFG_RESET_E)
    ) u_cfg_e (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .wr(CMD_VALID && is_cfg_set(CMD, `JPWV_NODE_E)),
        .byte_sel(CMD.verb[`JPWV_CFG_SEL_LSB-1:0]),
        .data(CMD.payload),
        .cfg(cfg_e)
    );

    jpwv_sync u_present (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .pin(JACK_E_PRESENT_PIN),
        .level(present_s)
    );

    // third jack list bit tracks the second converter
    assign widget_caps_f = `JPWV_WIDGET_CAPS_F_BASE |
        (SECOND_CONV_EN ? `JPWV_WIDGET_CAPS_LIST_MASK : `JPWV_RSP_ZERO);

    // detect override masks presence
    assign present_eff = present_s &&
        !cfg_e[`JPWV_CFG_OVERRIDE_BIT];
    assign insert = present_eff && !present_prev_q;

    always_comb begin
        rsp_d = `JPWV_RSP_ZERO;
        if (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_PARAM)) begin
            case (CMD.payload)
                `JPWV_PARAM_WIDGET_CAPS: rsp_d = WIDGET_CAPS_E;
                `JPWV_PARAM_PIN_CAPS: rsp_d = PIN_CAPS_E;
                `JPWV_PARAM_LISTLEN: rsp_d = `JPWV_LIST_LEN_E;
                default: rsp_d = `JPWV_RSP_ZERO;
            endcase
        end else if (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_LIST)) begin
            rsp_d = `JPWV_LIST_ENTRIES_E;
        end else if (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_PIN_CONTROL)) begin
            rsp_d = 32'(pin_control_q);
        end else if (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_UNSOL)) begin
            rsp_d = 32'(unsol_q);
        end else if (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_SENSE)) begin
            rsp_d = {present_eff, imp_q};
        end else if (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_CFG)) begin
            rsp_d = cfg_e;
        end else if (is_cmd(CMD, `JPWV_NODE_D, `JPWV_VERB_GET_CFG)) begin
            rsp_d = cfg_d;
        end else if (is_cmd(CMD, `JPWV_NODE_F, `JPWV_VERB_GET_PARAM) &&
                     (CMD.payload == `JPWV_PARAM_WIDGET_CAPS)) begin
            rsp_d = widget_caps_f;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= `JPWV_RSP_ZERO;
        end else if (CE) begin
            rsp_valid_q <= CMD_VALID;
            rsp_q <= CMD_VALID ? rsp_d : `JPWV_RSP_ZERO;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pin_control_q <= jpwv_pin_control_s'(`JPWV_PIN_CONTROL_RESET);
        end else if (take &&
                     is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_PIN_CONTROL)) begin
            pin_control_q.out_en <= pin_wr.out_en;
            pin_control_q.in_en <= pin_wr.in_en;
            pin_control_q.bias <= bias_fix(pin_wr.bias);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            unsol_q <= jpwv_unsol_s'(`JPWV_UNSOL_RESET);
        end else if (take &&
                     is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_UNSOL)) begin
            unsol_q.en <= CMD.payload[7];
            unsol_q.tag <= CMD.payload[5:0];
        end
    end

    // a new trigger while busy restarts the measurement
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sense_q <= JPWV_SENSE_IDLE;
            imp_q <= `JPWV_IMP_ALL_ONES;
            side_q <= 1'b0;
            start_q <= 1'b0;
        end else if (CE) begin
            start_q <= 1'b0;
            if (take && is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_SENSE)) begin
                sense_q <= JPWV_SENSE_BUSY;
                imp_q <= `JPWV_IMP_ALL_ONES;
                side_q <= CMD.payload[0];
                start_q <= 1'b1;
            end else begin
                case (sense_q)
                    JPWV_SENSE_IDLE: sense_q <= JPWV_SENSE_IDLE;
                    JPWV_SENSE_BUSY: begin
                        if (IMP_DONE) begin
                            sense_q <= JPWV_SENSE_IDLE;
                            imp_q <= IMP_VALUE;
                        end
                    end
                    default: sense_q <= JPWV_SENSE_IDLE;
                endcase
            end
        end
    end

    assign sense_done = (sense_q == JPWV_SENSE_BUSY) && IMP_DONE &&
        !(CMD_VALID && is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_SENSE));
    assign unsol_event = unsol_q.en && (insert || sense_done);
    // a new event wins over the acceptance of the old one
    assign pending_d = unsol_event ||
        (pending_q && !UNSOL_READY);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            present_prev_q <= 1'b0;
            pending_q <= 1'b0;
            unsol_data_q <= `JPWV_RSP_ZERO;
        end else if (CE) begin
            present_prev_q <= present_eff;
            pending_q <= pending_d;
            if (unsol_event) begin
                unsol_data_q <= {unsol_q.tag, `JPWV_UNSOL_PAD};
            end
        end
    end

    assign RSP_VALID = rsp_valid_q;
    assign RSP_DATA = rsp_q;
    assign UNSOL_VALID = pending_q;
    assign UNSOL_DATA = unsol_data_q;
    assign IMP_START = start_q;
    assign IMP_RIGHT = side_q;
    assign JACK_E_OUT_EN = pin_control_q.out_en;
    assign JACK_E_IN_EN = pin_control_q.in_en;
    assign JACK_E_BIAS = pin_control_q.bias;
    assign JACK_D_DETECT_OVERRIDE = cfg_d[`JPWV_CFG_OVERRIDE_BIT];

    sequence sense_trig_s;
        take && is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_SENSE);
    endsequence

    sequence sense_finish_s;
        CE && sense_done && unsol_q.en;
    endsequence

    set_resp_zero_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        take && (is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_PIN_CONTROL) ||
                 is_cfg_set(CMD, `JPWV_NODE_D))
        |=> RSP_VALID && (RSP_DATA == `JPWV_RSP_ZERO))
        else $error("set verb answer not zero");

    cfg_read_back_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        take && is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_CFG)
        |=> RSP_DATA == $past(cfg_e))
        else $error("configuration read mismatch");

    cfg_reset_d_a: assert property (
        @(posedge CLK_SYS) $past(SRST) && !SRST
        |-> cfg_d == `JPWV_CFG_RESET_D)
        else $error("headphone configuration reset wrong");

    cfg_reset_e_a: assert property (
        @(posedge CLK_SYS) $past(SRST) && !SRST
        |-> cfg_e == `JPWV_CFG_RESET_E &&
            cfg_e[`JPWV_CFG_MISC_HI:`JPWV_CFG_MISC_LO] == 4'h0)
        else $error("second jack configuration reset wrong");

    cfg_byte_write_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        take && is_cfg_set(CMD, `JPWV_NODE_E) &&
        CMD.verb[`JPWV_CFG_SEL_LSB-1:0] == 2'h3
        |=> cfg_e[31:24] == $past(CMD.payload) &&
            cfg_e[23:0] == $past(cfg_e[23:0]))
        else $error("configuration byte write wrong");

    widget_caps_read_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        take && is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_GET_PARAM) &&
        CMD.payload == `JPWV_PARAM_WIDGET_CAPS
        |=> RSP_DATA == 32'h0040_0181)
        else $error("widget capabilities wrong");

    bias_fallback_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        take && is_cmd(CMD, `JPWV_NODE_E, `JPWV_VERB_SET_PIN_CONTROL) &&
        !BIAS_CAPS[pin_wr.bias]
        |=> JACK_E_BIAS == `JPWV_BIAS_HIZ)
        else $error("unsupported bias level kept");

    insert_unsol_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        CE && insert && unsol_q.en |=> UNSOL_VALID)
        else $error("insertion gave no unsolicited reply");

    sense_unsol_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        sense_trig_s ##[1:100] sense_finish_s |=> UNSOL_VALID)
        else $error("sense completion gave no unsolicited reply");

    unsol_tag_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        CE && unsol_event |=> UNSOL_DATA[31:26] == $past(unsol_q.tag))
        else $error("unsolicited tag wrong");

    imp_busy_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        sense_trig_s |=> (imp_q == `JPWV_IMP_ALL_ONES)
            throughout (sense_q == JPWV_SENSE_BUSY)[*1])
        else $error("impedance not all ones while busy");

    list_f_bit_a: assert property (
        @(posedge CLK_SYS) disable iff (SRST)
        take && is_cmd(CMD, `JPWV_NODE_F, `JPWV_VERB_GET_PARAM) &&
        CMD.payload == `JPWV_PARAM_WIDGET_CAPS
        |=> RSP_DATA[8] == $past(SECOND_CONV_EN))
        else $error("third jack list bit wrong");
endmodule

// ---- tb_top.sv ----
// self-checking bench for the jack pin widget verb block
`timescale 1ns/100ps
module tb_top;
    import jpwv_pkg::*;
    typedef struct packed {
        logic [6:0] n;
        logic [11:0] v;
        logic [7:0] p;
        logic [31:0] e;
    } jpwv_row_s;
    localparam jpwv_row_s ROWS [12] = '{
        '{7'h0D, 12'hF1C, 8'h00, 32'h0121_401F},
        '{7'h0E, 12'hF1C, 8'h00, 32'h0101_1010},
        '{7'h0E, 12'hF00, 8'h09, 32'h0040_0181},
        '{7'h0E, 12'hF00, 8'h0C, 32'h0000_1737},
        '{7'h0E, 12'hF00, 8'h0E, 32'h0000_0001},
        '{7'h0E, 12'hF02, 8'h00, 32'h0000_0010},
        '{7'h0E, 12'hF07, 8'h00, 32'h0000_0000},
        '{7'h0E, 12'hF08, 8'h00, 32'h0000_0000},
        '{7'h0E, 12'hF09, 8'h00, 32'h7FFF_FFFF},
        '{7'h0F, 12'hF00, 8'h09, 32'h0040_0081},
        '{7'h0E, 12'h708, 8'h00, 32'h0000_0000},
        '{7'h0D, 12'h71F, 8'h01, 32'h0000_0000}
    };
    localparam logic [7:0] BIAS_OK = 8'h17;
    // group association 5, sequence A: nonzero group, unique sequence
    localparam logic [31:0] CFGW = 32'hC3A5_0F5A;
    logic CLK_SYS = 1'b0;
    logic SRST = 1'b1;
    logic CE = 1'b1;
    logic CMD_VALID = 1'b0;
    jpwv_cmd_s CMD = '0;
    jpwv_word_t RSP_DATA, UNSOL_DATA, rsp;
    logic RSP_VALID, UNSOL_VALID, IMP_START, IMP_RIGHT, IMP_DONE;
    logic UNSOL_READY = 1'b0;
    logic JACK_E_PRESENT_PIN = 1'b0;
    logic SECOND_CONV_EN = 1'b0;
    logic [30:0] IMP_VALUE;
    logic JACK_E_OUT_EN, JACK_E_IN_EN, JACK_D_DETECT_OVERRIDE;
    logic [2:0] JACK_E_BIAS, eb;
    logic [7:0] dly = 8'h14;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    always #2 CLK_SYS = ~CLK_SYS;
    jpwv_top u_jpwv_top (.CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE),
        .CMD_VALID(CMD_VALID), .CMD(CMD), .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA), .UNSOL_VALID(UNSOL_VALID),
        .UNSOL_READY(UNSOL_READY), .UNSOL_DATA(UNSOL_DATA),
        .JACK_E_PRESENT_PIN(JACK_E_PRESENT_PIN),
        .SECOND_CONV_EN(SECOND_CONV_EN), .IMP_START(IMP_START),
        .IMP_RIGHT(IMP_RIGHT), .IMP_DONE(IMP_DONE),
        .IMP_VALUE(IMP_VALUE), .JACK_E_OUT_EN(JACK_E_OUT_EN),
        .JACK_E_IN_EN(JACK_E_IN_EN), .JACK_E_BIAS(JACK_E_BIAS),
        .JACK_D_DETECT_OVERRIDE(JACK_D_DETECT_OVERRIDE));
    jpwv_meas_model u_jpwv_meas_model (.clk(CLK_SYS), .srst(SRST),
        .dly(dly), .start(IMP_START), .right(IMP_RIGHT),
        .done(IMP_DONE), .value(IMP_VALUE));
    task automatic final_report();
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input logic [6:0] n, input logic [11:0] v,
                       input logic [7:0] p);
        CMD_VALID = 1'b1;
        CMD = {n, v, p};
        @(posedge CLK_SYS);
        #1;
        rsp = RSP_DATA;
        chk("rsp_valid", 32'h1, {31'h0, RSP_VALID});
    endtask
    task automatic idle();
        CMD_VALID = 1'b0;
        @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wait_unsol();
        int n;
        n = 0;
        while (UNSOL_VALID !== 1'b1 && n < 60) begin
            idle();
            n++;
        end
        chk("unsol_valid", 32'h1, {31'h0, UNSOL_VALID});
        chk("unsol_data", 32'hAC00_0000, UNSOL_DATA);
    endtask
    task automatic take();
        UNSOL_READY = 1'b1;
        @(posedge CLK_SYS);
        #1;
        UNSOL_READY = 1'b0;
        chk("unsol_taken", 32'h0, {31'h0, UNSOL_VALID});
    endtask
    task automatic run_rows();
        foreach (ROWS[i]) begin
            cmd(ROWS[i].n, ROWS[i].v, ROWS[i].p);
            chk("row", ROWS[i].e, rsp);
        end
        idle();
    endtask
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge CLK_SYS);
        #1;
        SRST = 1'b0;
        run_rows();
        for (int b = 0; b < 8; b++) begin
            eb = BIAS_OK[b] ? b[2:0] : 3'h0;
            cmd(7'h0E, 12'h707, 8'hF8 | b[7:0]);
            chk("set_rsp", 32'h0, rsp);
            cmd(7'h0E, 12'hF07, 8'h00);
            chk("pin_ctl", {24'h0, 5'h0C, eb}, rsp);
            chk("bias", {29'h0, eb}, {29'h0, JACK_E_BIAS});
            chk("paths", 32'h3,
                {30'h0, JACK_E_OUT_EN, JACK_E_IN_EN});
        end
        // clock enable low must leave pin control untouched
        CE = 1'b0;
        cmd(7'h0E, 12'h707, 8'h04);
        CE = 1'b1;
        cmd(7'h0E, 12'hF07, 8'h00);
        chk("ce_hold", 32'h0000_0060, rsp);
        for (int k = 0; k < 4; k++) begin
            cmd(7'h0D, {10'h1C7, k[1:0]}, CFGW[8*k +: 8]);
        end
        cmd(7'h0D, 12'hF1C, 8'h00);
        chk("cfg_d", CFGW, rsp);
        chk("ovr_on", 32'h1, {31'h0, JACK_D_DETECT_OVERRIDE});
        cmd(7'h0D, 12'h71D, 8'h00);
        cmd(7'h0D, 12'hF1C, 8'h00);
        chk("cfg_d2", 32'hC3A5_005A, rsp);
        chk("ovr_off", 32'h0, {31'h0, JACK_D_DETECT_OVERRIDE});
        cmd(7'h0E, 12'h708, 8'hAB);
        cmd(7'h0E, 12'hF08, 8'h00);
        chk("unsol_ctl", 32'h0000_00AB, rsp);
        idle();
        JACK_E_PRESENT_PIN = 1'b1;
        wait_unsol();
        idle();
        idle();
        chk("unsol_held", 32'h1, {31'h0, UNSOL_VALID});
        take();
        cmd(7'h0E, 12'hF09, 8'h00);
        chk("present", 32'hFFFF_FFFF, rsp);
        // host triggers before trusting the reading
        cmd(7'h0E, 12'h709, 8'h01);
        chk("start_r", 32'h3, {30'h0, IMP_START, IMP_RIGHT});
        chk("sense_set", 32'h0, rsp);
        cmd(7'h0E, 12'hF09, 8'h00);
        chk("busy", 32'hFFFF_FFFF, rsp);
        idle();
        wait_unsol();
        take();
        cmd(7'h0E, 12'hF09, 8'h00);
        chk("imp_r", 32'h8000_1234, rsp);
        dly = 8'h00;
        cmd(7'h0E, 12'h709, 8'h00);
        chk("start_l", 32'h2, {30'h0, IMP_START, IMP_RIGHT});
        idle();
        wait_unsol();
        take();
        cmd(7'h0E, 12'h71D, 8'h11);
        cmd(7'h0E, 12'hF09, 8'h00);
        chk("imp_l_ovr", 32'h0000_0567, rsp);
        cmd(7'h0E, 12'h71F, 8'h02);
        cmd(7'h0E, 12'hF1C, 8'h00);
        chk("cfg_e", 32'h0201_1110, rsp);
        SECOND_CONV_EN = 1'b1;
        cmd(7'h0F, 12'hF00, 8'h09);
        chk("widget_caps_f", 32'h0040_0181, rsp);
        idle();
        JACK_E_PRESENT_PIN = 1'b0;
        SECOND_CONV_EN = 1'b0;
        SRST = 1'b1;
        idle();
        SRST = 1'b0;
        run_rows();
        final_report();
    end
endmodule
